/* File: rtl/ood_decoder.sv */
/*
  Registered opcode/level decoder: classifies primary, function and
  rt-field encodings by architecture level and flags exceptions.
  Assumes fetch presents instr with instr_valid; level and enables are
  stable while the word is decoded. Results appear one edge later.
*/
// Functional notes
// - primary opcode is bits 31..26, upper three row, lower three column
// - register-immediate class decodes rt bits 20..16, 20..19 row, 18..16 column
// - secondary class decodes function bits 5..0, upper row, lower column
// - reserved-for-future encodings raise reserved instruction
// - undefined-result encodings may do anything; here they raise reserved instruction
// - class entries are never executed; decoded through their secondary field
// - coprocessor operations raise coprocessor unusable without access
// - coprocessor-3 slots raise reserved instruction in level-3-only mode
// - fp condition-move class raises coprocessor unusable without coprocessor 1
// - system-control base-offset slot: decoded if implemented and level 2 or above, unusable without coprocessor 0, else reserved
// - level 2 adds likely branches, linked word, coprocessor doubleword memory
// - level 2 adds barrier, register traps, rt likely branches, immediate traps
// - level 3 retires coprocessor-3 slots and adds doubleword memory ops
// - level 3 adds doubleword shifts, multiply/divide, add/subtract
// - level 4 adds fp extended class, prefetch, condition moves
// - floating-point ops with coprocessor 1 disabled raise coprocessor unusable
`timescale 1ns/10ps
`default_nettype none
module ood_decoder #(
  parameter bit COP0_BASE_IMPL = 1'b0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // instruction from fetch
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  // processor state
  input wire logic [2:0] arch_level,
  input wire logic [3:0] cop_usable,
  // decode result
  output logic dec_valid_q,
  output var ood_pkg::ood_op_t dec_op_q,
  output logic reserved_instr_q,
  output logic cop_unusable_q
);

  logic [5:0] opc;
  logic [5:0] fn;
  logic [4:0] rt;
  logic [2:0] op_row;
  logic [2:0] op_col;
  logic [2:0] fn_row;
  logic [2:0] fn_col;
  logic [1:0] rt_row;
  logic [2:0] rt_col;
  logic lv2;
  logic lv3;
  logic lv4;
  ood_pkg::ood_op_t op_d;
  logic cu_d;
  logic ri_d;

  assign opc = instr[ood_pkg::OP_HI:ood_pkg::OP_LO];
  assign op_row = opc[5:3];
  assign op_col = opc[2:0];
  assign fn = instr[ood_pkg::FN_HI:ood_pkg::FN_LO];
  assign fn_row = fn[5:3];
  assign fn_col = fn[2:0];
  assign rt = instr[ood_pkg::RT_HI:ood_pkg::RT_LO];
  assign rt_row = rt[4:3];
  assign rt_col = rt[2:0];
  assign lv2 = arch_level >= ood_pkg::LVL_2;
  assign lv3 = arch_level >= ood_pkg::LVL_3;
  assign lv4 = arch_level >= ood_pkg::LVL_4;

  // one combinational pass; unusable is judged before reserved
  always_comb begin
    op_d = ood_pkg::OOD_RESERVED;
    cu_d = 1'b0;
    if (opc == ood_pkg::OP_SECONDARY) begin
      // class entry: operation comes from the function field
      unique case (fn_row)
        3'h0: begin
          if (fn_col == 3'h1) begin
            if (lv4) begin
              op_d = ood_pkg::OOD_FP_CONDITION_MOVE_CLASS;
              cu_d = !cop_usable[1];
            end
          end else if (fn_col != 3'h5) begin
            op_d = ood_pkg::OOD_BASE;
          end
        end
        3'h1: begin
          unique case (fn_col)
            3'h0, 3'h1, 3'h4, 3'h5: op_d = ood_pkg::OOD_BASE;
            3'h2: op_d = lv4 ? ood_pkg::OOD_MOVE_ON_ZERO : ood_pkg::OOD_RESERVED;
            3'h3: op_d = lv4 ? ood_pkg::OOD_MOVE_ON_NONZERO : ood_pkg::OOD_RESERVED;
            3'h7: op_d = lv2 ? ood_pkg::OOD_MEMORY_BARRIER : ood_pkg::OOD_RESERVED;
            3'h6: op_d = ood_pkg::OOD_RESERVED;
          endcase
        end
        3'h2: begin
          if (!fn_col[2]) begin
            op_d = ood_pkg::OOD_BASE;
          end else if (fn_col != 3'h5 && lv3) begin
            op_d = ood_pkg::OOD_DOUBLE_SHIFT_VARIABLE;
          end
        end
        3'h3: begin
          if (!fn_col[2]) begin
            op_d = ood_pkg::OOD_BASE;
          end else if (lv3) begin
            op_d = ood_pkg::OOD_DOUBLE_MULTIPLY;
          end
        end
        3'h4: op_d = ood_pkg::OOD_BASE;
        3'h5: begin
          if (fn_col == 3'h2 || fn_col == 3'h3) begin
            op_d = ood_pkg::OOD_BASE;
          end else if (fn_col[2] && lv3) begin
            op_d = ood_pkg::OOD_DOUBLE_ADD;
          end
        end
        3'h6: begin
          if (fn_col != 3'h5 && fn_col != 3'h7 && lv2) begin
            op_d = ood_pkg::OOD_TRAP_REGISTER;
          end
        end
        3'h7: begin
          if (fn_col != 3'h1 && fn_col != 3'h5 && lv3) begin
            op_d = ood_pkg::OOD_DOUBLE_SHIFT;
          end
        end
      endcase
    end else if (opc == ood_pkg::OP_REGISTER_IMMEDIATE_CLASS) begin
      // class entry: operation comes from the rt field
      unique case (rt_row)
        2'h0, 2'h2: begin
          if (rt_col[2:1] == 2'h0) begin
            op_d = ood_pkg::OOD_BASE;
          end else if (rt_col[2:1] == 2'h1 && lv2) begin
            op_d = ood_pkg::OOD_LIKELY_BRANCH;
          end else if (!lv2) begin
            op_d = ood_pkg::OOD_UNDEFINED;
          end
        end
        2'h1: begin
          if (lv2 && rt_col != 3'h5 && rt_col != 3'h7) begin
            op_d = ood_pkg::OOD_TRAP_IMMEDIATE;
          end else if (!lv2) begin
            op_d = ood_pkg::OOD_UNDEFINED;
          end
        end
        2'h3: op_d = lv2 ? ood_pkg::OOD_RESERVED : ood_pkg::OOD_UNDEFINED;
      endcase
    end else begin
      unique case (op_row)
        3'h0, 3'h1: op_d = ood_pkg::OOD_BASE;
        3'h2: begin
          if (op_col[2]) begin
            if (lv2) begin
              op_d = ood_pkg::OOD_LIKELY_BRANCH;
            end
          end else if (op_col == 3'h3) begin
            if (lv4) begin
              op_d = ood_pkg::OOD_FP_EXTENDED_CLASS;
              cu_d = !cop_usable[1];
            end else if (!lv3) begin
              op_d = ood_pkg::OOD_COPROC3_OPERATION;
              cu_d = !cop_usable[3];
            end
          end else begin
            op_d = ood_pkg::OOD_COPROC;
            cu_d = !cop_usable[op_col[1:0]];
          end
        end
        3'h3: begin
          if (!op_col[2] && lv3) begin
            op_d = op_col[1] ? ood_pkg::OOD_DOUBLE_UNALIGNED : ood_pkg::OOD_DOUBLE_ADD_IMMEDIATE;
          end
        end
        3'h4: begin
          if (op_col != 3'h7) begin
            op_d = ood_pkg::OOD_BASE;
          end else if (lv3) begin
            op_d = ood_pkg::OOD_LOAD_WORD_ZERO_EXTEND;
          end
        end
        3'h5: begin
          if (opc == ood_pkg::OP_COP0_BASE_SLOT) begin
            if (lv2 && COP0_BASE_IMPL) begin
              op_d = ood_pkg::OOD_COP0_BASE_OFFSET;
              cu_d = !cop_usable[0];
            end
          end else if (op_col[2:1] == 2'h2) begin
            if (lv3) begin
              op_d = ood_pkg::OOD_DOUBLE_UNALIGNED;
            end
          end else begin
            op_d = ood_pkg::OOD_BASE;
          end
        end
        3'h6, 3'h7: begin
          unique case (op_col)
            3'h0: begin
              if (lv2) begin
                op_d = op_row[0] ? ood_pkg::OOD_STORE_CONDITIONAL_WORD : ood_pkg::OOD_LOAD_LINKED_WORD;
              end
            end
            3'h1, 3'h2: begin
              op_d = ood_pkg::OOD_COPROC;
              cu_d = !cop_usable[op_col[1:0]];
            end
            3'h3: begin
              if (lv4 && !op_row[0]) begin
                op_d = ood_pkg::OOD_PREFETCH_OP;
              end else if (!lv3) begin
                op_d = ood_pkg::OOD_COPROC3_MEM;
                cu_d = !cop_usable[3];
              end
            end
            3'h4: begin
              if (lv3) begin
                op_d = ood_pkg::OOD_LINKED_DOUBLE;
              end
            end
            3'h5, 3'h6: begin
              if (lv2) begin
                op_d = ood_pkg::OOD_COPROC_DOUBLE_MEM;
                // column 101 serves coprocessor 1, column 110 coprocessor 2
                cu_d = !cop_usable[op_col[1:0]];
              end
            end
            3'h7: begin
              if (lv3) begin
                op_d = ood_pkg::OOD_DOUBLE_MEM;
              end else if (lv2) begin
                op_d = ood_pkg::OOD_COPROC3_MEM;
                cu_d = !cop_usable[3];
              end
            end
          endcase
        end
      endcase
    end
    // reserved only where no unusable condition stands
    ri_d = !cu_d && (op_d == ood_pkg::OOD_RESERVED || op_d == ood_pkg::OOD_UNDEFINED);
  end

  // answer qualifier: one edge after each request
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      dec_valid_q <= 1'b0;
    end else begin
      dec_valid_q <= instr_valid;
    end
  end

  // idle cycles show no operation, so a stale group never leaks
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      dec_op_q <= ood_pkg::OOD_NONE;
    end else begin
      dec_op_q <= instr_valid ? op_d : ood_pkg::OOD_NONE;
    end
  end

  // reserved flag
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      reserved_instr_q <= 1'b0;
    end else begin
      reserved_instr_q <= instr_valid && ri_d;
    end
  end

  // unusable flag
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cop_unusable_q <= 1'b0;
    end else begin
      cop_unusable_q <= instr_valid && cu_d;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/ood_pkg.sv */
/*
  Constants and operation codes for the opcode/level decoder.
  Assumes a 32-bit instruction word and a level input coded 1..4.
*/
package ood_pkg;
  // instruction fields
  localparam int OP_HI = 31;
  localparam int OP_LO = 26;
  localparam int RT_HI = 20;
  localparam int RT_LO = 16;
  localparam int FN_HI = 5;
  localparam int FN_LO = 0;
  // architecture levels
  localparam logic [2:0] LVL_2 = 3'h2;
  localparam logic [2:0] LVL_3 = 3'h3;
  localparam logic [2:0] LVL_4 = 3'h4;
  // primary opcodes that select a class or a special slot
  localparam logic [5:0] OP_SECONDARY = 6'h00;
  localparam logic [5:0] OP_REGISTER_IMMEDIATE_CLASS = 6'h01;
  localparam logic [5:0] OP_COPROC3_OPERATION_SLOT = 6'h13;
  localparam logic [5:0] OP_COP0_BASE_SLOT = 6'h2f;
  // decoded operation groups
  typedef enum logic [5:0] {
    OOD_NONE, OOD_BASE, OOD_COPROC, OOD_FP_EXTENDED_CLASS, OOD_LIKELY_BRANCH,
    OOD_LOAD_LINKED_WORD, OOD_STORE_CONDITIONAL_WORD, OOD_COPROC_DOUBLE_MEM,
    OOD_COPROC3_OPERATION, OOD_COPROC3_MEM, OOD_DOUBLE_ADD_IMMEDIATE,
    OOD_DOUBLE_UNALIGNED, OOD_LOAD_WORD_ZERO_EXTEND, OOD_DOUBLE_MEM,
    OOD_LINKED_DOUBLE, OOD_PREFETCH_OP, OOD_COP0_BASE_OFFSET,
    OOD_MEMORY_BARRIER, OOD_TRAP_REGISTER, OOD_DOUBLE_SHIFT_VARIABLE,
    OOD_DOUBLE_MULTIPLY, OOD_DOUBLE_ADD, OOD_DOUBLE_SHIFT,
    OOD_FP_CONDITION_MOVE_CLASS, OOD_MOVE_ON_ZERO, OOD_MOVE_ON_NONZERO,
    OOD_TRAP_IMMEDIATE, OOD_RESERVED, OOD_UNDEFINED
  } ood_op_t;
endpackage

/* File: verification/ood_checker.sv */
/*
  Checker for ood_decoder, bound to every instance.
  Assumes results one edge after each request.
*/
`timescale 1ns/10ps
`default_nettype none
module ood_checker #(
  parameter bit COP0_BASE_IMPL = 1'b0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // request side
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire logic [2:0] arch_level,
  input wire logic [3:0] cop_usable,
  // results
  input wire logic dec_valid_q,
  input wire ood_pkg::ood_op_t dec_op_q,
  input wire logic reserved_instr_q,
  input wire logic cop_unusable_q
);
  wire logic [5:0] op = instr[31:26];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  answer_latency_a: assert property (instr_valid |=> dec_valid_q) else $error("late");
  idle_quiet_a: assert property (!instr_valid |=> !dec_valid_q && !reserved_instr_q && !cop_unusable_q
    && dec_op_q == ood_pkg::OOD_NONE) else $error("idle");
  flags_apart_a: assert property (!(reserved_instr_q && cop_unusable_q)) else $error("both");
  future_slot_a: assert property (instr_valid && op == 6'h1c |=> reserved_instr_q) else $error("ri");
  cop1_off_a: assert property (instr_valid && op == 6'h11 && !cop_usable[1] |=> cop_unusable_q)
    else $error("cu");
  coproc3_operation_retired_a: assert property (instr_valid && op == 6'h13 && arch_level == 3'h3 |=> reserved_instr_q)
    else $error("coproc3_operation");
  cond_move_a: assert property (instr_valid && instr == 32'h0000_0001 && arch_level == 3'h4 && !cop_usable[1]
    |=> cop_unusable_q) else $error("fp_condition_move_class");
  prefetch_a: assert property (instr_valid && op == 6'h33 && arch_level == 3'h4
    |=> dec_op_q == ood_pkg::OOD_PREFETCH_OP) else $error("prefetch_op");
  cop0_slot_a: assert property (instr_valid && op == 6'h2f && !COP0_BASE_IMPL |=> reserved_instr_q)
    else $error("cop0");
endmodule
bind ood_decoder ood_checker #(.COP0_BASE_IMPL(COP0_BASE_IMPL)) i_ood_checker (.sys_clk, .rst_b, .instr_valid,
  .instr, .arch_level, .cop_usable, .dec_valid_q, .dec_op_q, .reserved_instr_q, .cop_unusable_q);
`default_nettype wire

/* File: verification/ood_fetch_model.sv */
/*
  Fetch-stage model feeding ood_decoder one word per request.
  Assumes the bench raises req just after a clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module ood_fetch_model (
  // clock
  input wire logic sys_clk,
  // bench request
  input wire logic req,
  input wire logic [31:0] word,
  // to decoder
  output logic instr_valid,
  output logic [31:0] instr
);
  logic [31:0] last_q = 32'h0000_0000;
  // idle bus toggles, so a stale word never decodes by luck
  always_ff @(posedge sys_clk) begin
    last_q <= instr;
  end
  assign instr_valid = req;
  assign instr = req ? word : ~last_q;
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
/*
  Self-checking bench for ood_decoder behind the fetch model.
  Assumes each answer lands one edge after its request.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0, rst_b = 1'b0, req = 1'b0;
  logic [31:0] word = 32'h0000_0000;
  logic [2:0] arch_level = 3'h4;
  logic [3:0] cop_usable = 4'hf;
  wire logic instr_valid, dec_valid_q, reserved_instr_q, cop_unusable_q;
  wire logic [31:0] instr;
  wire ood_pkg::ood_op_t dec_op_q;
  int num_errors = 0, checks = 0;
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  ood_fetch_model i_ood_fetch_model (.sys_clk, .req, .word, .instr_valid, .instr);
  ood_decoder #(.COP0_BASE_IMPL(1'b0)) i_ood_decoder (.sys_clk, .rst_b, .instr_valid, .instr, .arch_level,
    .cop_usable, .dec_valid_q, .dec_op_q, .reserved_instr_q, .cop_unusable_q);
  // expecting OOD_NONE means coprocessor unusable, op left unjudged
  task automatic chk(input logic [2:0] lvl, input logic [3:0] cu, input logic [5:0] op, input logic [5:0] sub,
                     input ood_pkg::ood_op_t e_op, input logic rq = 1'b1);
    logic act;
    act = rq & rst_b;
    arch_level = lvl;
    cop_usable = cu;
    word = {op, 5'h00, (op == 6'h01) ? sub[4:0] : 5'h00, 10'h000, (op == 6'h01) ? 6'h00 : sub};
    req = rq;
    @(posedge sys_clk);
    #1;
    checks = checks + 1;
    if (dec_valid_q !== act || cop_unusable_q !== (act && e_op == ood_pkg::OOD_NONE)
        || reserved_instr_q !== (act && (e_op == ood_pkg::OOD_RESERVED || e_op == ood_pkg::OOD_UNDEFINED))
        || ((!act || e_op != ood_pkg::OOD_NONE) && dec_op_q !== (act ? e_op : ood_pkg::OOD_NONE))) begin
      num_errors = num_errors + 1;
      $display("unexpected at %0t: word %h level %0d op %0d", $time, word, lvl, dec_op_q);
    end
  endtask
  task automatic t_primary();
    chk(3'h1, 4'hf, 6'h23, 6'h00, ood_pkg::OOD_BASE);
    chk(3'h4, 4'hf, 6'h1c, 6'h00, ood_pkg::OOD_RESERVED);
    chk(3'h1, 4'hf, 6'h14, 6'h00, ood_pkg::OOD_RESERVED);
    chk(3'h2, 4'hf, 6'h30, 6'h00, ood_pkg::OOD_LOAD_LINKED_WORD);
    chk(3'h2, 4'hd, 6'h35, 6'h00, ood_pkg::OOD_NONE);
    chk(3'h2, 4'hf, 6'h13, 6'h00, ood_pkg::OOD_COPROC3_OPERATION);
    chk(3'h3, 4'hf, 6'h3b, 6'h00, ood_pkg::OOD_RESERVED);
    chk(3'h3, 4'hf, 6'h13, 6'h00, ood_pkg::OOD_RESERVED);
    chk(3'h2, 4'hb, 6'h36, 6'h00, ood_pkg::OOD_NONE);
    chk(3'h3, 4'hf, 6'h37, 6'h00, ood_pkg::OOD_DOUBLE_MEM);
    chk(3'h4, 4'hf, 6'h33, 6'h00, ood_pkg::OOD_PREFETCH_OP);
    chk(3'h4, 4'hf, 6'h2f, 6'h00, ood_pkg::OOD_RESERVED);
    chk(3'h2, 4'hd, 6'h11, 6'h00, ood_pkg::OOD_NONE);
  endtask
  task automatic t_function();
    chk(3'h2, 4'hf, 6'h00, 6'h0f, ood_pkg::OOD_MEMORY_BARRIER);
    chk(3'h3, 4'hf, 6'h00, 6'h1f, ood_pkg::OOD_DOUBLE_MULTIPLY);
    chk(3'h2, 4'hf, 6'h00, 6'h3f, ood_pkg::OOD_RESERVED);
    chk(3'h4, 4'hd, 6'h00, 6'h01, ood_pkg::OOD_NONE);
    chk(3'h4, 4'hf, 6'h00, 6'h0b, ood_pkg::OOD_MOVE_ON_NONZERO);
    chk(3'h1, 4'hf, 6'h00, 6'h20, ood_pkg::OOD_BASE);
    chk(3'h4, 4'hf, 6'h00, 6'h05, ood_pkg::OOD_RESERVED);
  endtask
  task automatic t_register_immediate_class();
    chk(3'h2, 4'hf, 6'h01, 6'h13, ood_pkg::OOD_LIKELY_BRANCH);
    chk(3'h1, 4'hf, 6'h01, 6'h02, ood_pkg::OOD_UNDEFINED);
    chk(3'h2, 4'hf, 6'h01, 6'h0e, ood_pkg::OOD_TRAP_IMMEDIATE);
    chk(3'h3, 4'hf, 6'h01, 6'h10, ood_pkg::OOD_BASE);
  endtask
  task automatic t_reset();
    rst_b = 1'b0;
    chk(3'h4, 4'hf, 6'h1c, 6'h00, ood_pkg::OOD_RESERVED);
    rst_b = 1'b1;
    chk(3'h4, 4'hf, 6'h1c, 6'h00, ood_pkg::OOD_NONE, 1'b0);
    chk(3'h4, 4'hf, 6'h1c, 6'h00, ood_pkg::OOD_RESERVED);
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    @(posedge sys_clk);
    #1;
    t_primary();
    t_function();
    t_register_immediate_class();
    t_reset();
    wrap_up();
  end
  initial begin
    #2000;
    num_errors = num_errors + 1;
    wrap_up();
  end
endmodule
`default_nettype wire
